/* rtl/input_sync.sv */
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // input_sync

/* rtl/start_guard.sv */
`timescale 1ns/1ps
`include "start_guard_cfg.svh"
// Function
// [R1] guard off: run at power-on starts immediately
// [R2] guard on: run at power-on trips, output off
// [R3] run off or reset clears guard trip
// [R4] fresh run after clear starts normally
// [R5] guard decides whether carried-over run resumes
// [R6] reset-cancel with run active restarts at once
// [R7] undervoltage reset pulse re-runs guard check
// [R8] controller waits three seconds before run; the code starts run on the synchronised run level with no such wait
// [R9] switchover assignable to terminal by code 14
// [R10] switchover off: wait, match, then accelerate
// [R11] low speed or fast decay starts 0 Hz
// [R12] controller lengthens wait after overcurrent trip; the code has no overcurrent input and always loads retry_wait_time
// [R13] reset held 12 ms, alarm cleared within 30 ms
// [R14] guard evaluated once after reset release
// [R15] wait counter loaded at switchover fall
module start_guard
  import start_guard_pkg::*;
#(
  parameter int TERMS = `TERM_COUNT,
  parameter int WAIT_W = `WAIT_W,
  parameter int FREQ_W = `FREQ_W,
  parameter int RESET_HOLD = `RESET_HOLD_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic run_cmd,
  input wire logic external_reset_input,
  input wire logic keypad_reset,
  input wire logic undervoltage_trip,
  input wire logic powerup_autorun_guard,
  input wire logic [TERMS-1:0] terminals,
  input wire logic [4:0] term_func [TERMS],
  input wire logic [WAIT_W-1:0] retry_wait_time,
  input wire logic [FREQ_W-1:0] motor_freq,
  input wire logic [FREQ_W-1:0] base_freq,
  input wire logic fast_decay,
  output drive_status_t status,
  output logic [FREQ_W-1:0] start_freq,
  output logic [2:0] guard_error
);
  localparam int HOLD_W = $clog2(RESET_HOLD + 1);
  logic run_s, rst_s, key_s, uv_s;
  logic [TERMS-1:0] term_s;
  logic cs_d, cs_q, rst_q, uv_q;
  logic [1:0] arm_q;
  logic [HOLD_W-1:0] hold_q;
  logic [WAIT_W-1:0] wait_q;
  logic reset_done, cs_fall, guard_check_q, guard_clear;
  logic guard_hit, cs_take;
  drive_state_t state_q;

  // terminals, run, reset, keypad and undervoltage inputs reach the logic two cycles late
  input_sync #(.WIDTH(TERMS + 4)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({terminals, run_cmd, external_reset_input, keypad_reset, undervoltage_trip}),
    .sync_out({term_s, run_s, rst_s, key_s, uv_s})
  );

  // switchover input from whichever terminal carries code 14
  always_comb begin
    cs_d = 1'b0;
    for (int i = 0; i < TERMS; i++) begin
      if (term_func[i] == `SWITCHOVER_CODE) cs_d = cs_d | term_s[i]; // [R9]
    end
  end

  // edge history and reset pulse width counter
  always_ff @(posedge clock) begin
    if (srst) begin
      cs_q <= 1'b0;
      rst_q <= 1'b0;
      uv_q <= 1'b0;
      hold_q <= '0;
    end else begin
      cs_q <= cs_d;
      rst_q <= rst_s;
      // set wins over the clear when a new dip lands on the reset edge
      if (uv_s) uv_q <= 1'h1; // [R7]
      else if (uv_q && reset_done) uv_q <= 1'h0;
      if (!rst_s) hold_q <= '0;
      else if (hold_q != HOLD_W'(RESET_HOLD)) hold_q <= hold_q + HOLD_W'(1);
    end
  end
  // short reset pulses count as glitches
  assign reset_done = (rst_q && !rst_s && hold_q == HOLD_W'(RESET_HOLD)) || key_s; // [R13]
  assign cs_fall = cs_q && !cs_d;
  assign guard_clear = !run_s || reset_done; // [R3]
  // guard trip wins over the switchover restart on the check cycle
  assign guard_hit = guard_check_q && run_s && powerup_autorun_guard; // [R2] [R5]
  // an undervoltage trip or a pending guard blocks the restart
  assign cs_take = cs_fall && run_s && state_q != st_guard && !uv_q && !guard_hit; // [R10]

  // one-shot guard check armed at reset release or undervoltage reset;
  // the arm bit is delayed two cycles so that the check meets the
  // first synchronised run level, not the reset value of the syncs
  always_ff @(posedge clock) begin
    if (srst) begin
      arm_q <= 2'h1;
      guard_check_q <= 1'h0;
    end else begin
      arm_q <= {arm_q[0], 1'h0};
      guard_check_q <= arm_q[1] || (uv_q && reset_done); // [R14] [R7]
    end
  end

  // drive sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= st_stop;
      wait_q <= '0;
    end else begin
      case (state_q)
        st_stop: begin
          if (guard_hit) state_q <= st_guard; // [R2] [R5]
          else if (run_s && !cs_d && !uv_q) state_q <= st_run; // [R1] [R4]
        end
        st_run: begin
          // switchover high hands the motor to the mains
          if (cs_d) state_q <= st_stop;
          else if (!run_s || uv_q) state_q <= st_stop; // [R7]
        end
        st_guard: begin
          if (reset_done && run_s) state_q <= st_run; // [R6]
          else if (guard_clear) state_q <= st_stop; // [R3]
        end
        st_wait: begin
          if (!run_s || uv_q) state_q <= st_stop;
          else if (wait_q == '0) state_q <= st_match; // [R15]
          else wait_q <= wait_q - WAIT_W'(1);
        end
        st_match: state_q <= run_s ? st_run : st_stop; // [R10]
        default: state_q <= st_stop;
      endcase
      // switchover fall overrides whatever the case chose
      if (cs_take) begin
        state_q <= st_wait;
        wait_q <= retry_wait_time; // [R15]
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
      start_freq <= '0;
      guard_error <= 3'h0;
    end else begin
      status.drive_on <= (state_q == st_run) || (state_q == st_match);
      status.guard_trip <= state_q == st_guard;
      status.alarm <= state_q == st_guard; // [R13]
      status.freq_match <= state_q == st_match;
      guard_error <= (state_q == st_guard) ? `GUARD_ERR_CODE : 3'h0; // [R2]
      if (state_q == st_wait && wait_q == '0) begin
        status.zero_start <= fast_decay || (motor_freq <= (base_freq >> 1)); // [R11]
        start_freq <= (fast_decay || (motor_freq <= (base_freq >> 1))) ? '0 : motor_freq; // [R10] [R11]
      end
    end
  end

  // checks on state, with the one cycle of output lag in mind
  a_guard_blocks_drive: assert property (@(posedge clock) disable iff (srst) // [R2]
    status.guard_trip |-> !status.drive_on) else $error("drive on during guard trip");
  a_guard_entry: assert property (@(posedge clock) disable iff (srst) // [R14]
    (state_q == st_stop && guard_check_q && run_s && powerup_autorun_guard) |=> state_q == st_guard)
    else $error("guard not entered");
  a_no_guard_run: assert property (@(posedge clock) disable iff (srst) // [R1]
    (state_q == st_stop && run_s && !powerup_autorun_guard && !cs_d && !cs_fall && !uv_q) |=> state_q == st_run)
    else $error("guard off run not started");
  a_guard_clear_run: assert property (@(posedge clock) disable iff (srst) // [R3]
    (state_q == st_guard && !run_s && !reset_done && !cs_fall) |=> state_q == st_stop)
    else $error("run off did not clear guard");
  a_reset_restart: assert property (@(posedge clock) disable iff (srst) // [R6]
    (state_q == st_guard && reset_done && run_s && !cs_fall) |=> state_q == st_run)
    else $error("reset did not restart");
  a_wait_load: assert property (@(posedge clock) disable iff (srst) // [R15]
    (cs_fall && run_s && state_q != st_guard && !uv_q && !guard_hit)
    |=> (state_q == st_wait && wait_q == $past(retry_wait_time)))
    else $error("wait not loaded");
  a_match_after_wait: assert property (@(posedge clock) disable iff (srst) // [R10]
    (state_q == st_wait && wait_q == '0 && run_s && !cs_fall && !uv_q) |=> state_q == st_match)
    else $error("match not after wait");
  a_alarm_follows: assert property (@(posedge clock) disable iff (srst) // [R13]
    (state_q == st_guard) |=> status.alarm) else $error("alarm missing");

  // undervoltage trip takes the drive off until the reset pulse
  a_uv_holds_off: assert property (@(posedge clock) disable iff (srst) // [R7]
    (state_q == st_run && uv_q) |=> state_q == st_stop)
    else $error("drive kept on after undervoltage");

  // check pulse lasts one cycle unless a fresh dip rearms it
  a_guard_one_shot: assert property (@(posedge clock) disable iff (srst) // [R14]
    (guard_check_q && !$past(uv_s)) |=> !guard_check_q)
    else $error("guard check repeated");

  // a trip without reset never leads straight back to run
  a_guard_no_restart: assert property (@(posedge clock) disable iff (srst) // [R5]
    (state_q == st_guard && !reset_done) |=> state_q != st_run)
    else $error("run resumed from guard trip");

  // switchover high hands the load over and stops the drive
  a_switch_stops: assert property (@(posedge clock) disable iff (srst) // [R10]
    (state_q == st_run && cs_d) |=> state_q == st_stop)
    else $error("drive on with switchover high");

  // retry wait steps down by one per clock
  a_wait_counts: assert property (@(posedge clock) disable iff (srst) // [R15]
    (state_q == st_wait && wait_q != '0 && run_s && !uv_q && !cs_fall)
    |=> (state_q == st_wait && wait_q == $past(wait_q) - WAIT_W'(1)))
    else $error("wait count skipped");

  // fast decay always restarts from zero frequency
  a_zero_start: assert property (@(posedge clock) disable iff (srst) // [R11]
    (state_q == st_wait && wait_q == '0 && fast_decay) |=> (status.zero_start && start_freq == '0))
    else $error("no zero start on fast decay");

  // error code shown for as long as the trip lasts
  a_error_code: assert property (@(posedge clock) disable iff (srst) // [R2]
    (state_q == st_guard) |=> guard_error == `GUARD_ERR_CODE)
    else $error("guard error code missing");
endmodule // start_guard

/* rtl/start_guard_cfg.svh */
`ifndef START_GUARD_CFG_SVH
`define START_GUARD_CFG_SVH
`define CLK_HZ 20000000
`define RESET_HOLD_MS 12
`define ALARM_CLEAR_MS 30
`define RESET_HOLD_CYC ((`CLK_HZ / 1000) * `RESET_HOLD_MS)
`define SWITCHOVER_CODE 5'h0E
`define GUARD_ERR_CODE 3'h1
`define TERM_COUNT 7
`define WAIT_W 16
`define FREQ_W 16
`endif

/* rtl/start_guard_pkg.sv */
package start_guard_pkg;
  typedef enum logic [2:0] {
    st_stop = 3'h0,
    st_run = 3'h1,
    st_wait = 3'h3,
    st_match = 3'h2,
    st_guard = 3'h6
  } drive_state_t;
  typedef struct packed {
    logic run;
    logic reset_n_unused;
  } unused_t;
  typedef struct packed {
    logic drive_on;
    logic guard_trip;
    logic alarm;
    logic freq_match;
    logic zero_start;
  } drive_status_t;
endpackage

/* test/terminal_ctrl.sv */
`timescale 1ns/1ps
module terminal_ctrl #(
  parameter int HOLD = 4
) (
  input wire logic clock,
  input wire logic run_req,
  input wire logic reset_req,
  output logic run_cmd,
  output logic external_reset_input
);
  int hold_q = 0;
  initial run_cmd = 1'b0;
  initial external_reset_input = 1'b0;
  // terminals move away from the sampling edge
  always @(negedge clock) run_cmd <= run_req;
  // pulse kept past the minimum, a retrigger waits for the end
  always @(negedge clock) begin
    if (reset_req && hold_q == 0) hold_q <= HOLD + 2;
    else if (hold_q != 0) hold_q <= hold_q - 1;
    external_reset_input <= (hold_q > 1);
  end
endmodule // terminal_ctrl

/* test/test_start_guard.sv */
`timescale 1ns/1ps
`include "start_guard_cfg.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); err_count++; end end
module test_start_guard;
  import start_guard_pkg::*;
  logic clock = 0, srst = 1, run_req = 0, reset_req = 0, key_rst = 0, uv = 0, guard = 0, fd = 0;
  logic run_cmd, ext_rst;
  logic [6:0] terms = 7'h00;
  logic [4:0] tf [7] = '{default: 5'h00};
  logic [15:0] wait_t = 16'h0001, motor_f = 16'h0000, base_f = 16'h1000, start_freq;
  logic [2:0] guard_error;
  drive_status_t status;
  int err_count = 0, comparisons = 0, n, k;
  initial forever #25 clock = ~clock;
  terminal_ctrl #(.HOLD(4)) ctrl (.clock(clock), .run_req(run_req), .reset_req(reset_req),
    .run_cmd(run_cmd), .external_reset_input(ext_rst));
  start_guard #(.RESET_HOLD(4)) DUT (.clock(clock), .srst(srst), .run_cmd(run_cmd),
    .external_reset_input(ext_rst), .keypad_reset(key_rst), .undervoltage_trip(uv),
    .powerup_autorun_guard(guard), .terminals(terms), .term_func(tf), .retry_wait_time(wait_t),
    .motor_freq(motor_f), .base_freq(base_f), .fast_decay(fd), .status(status),
    .start_freq(start_freq), .guard_error(guard_error));
  // zero start when slow or fast decaying
  function automatic logic zero_exp(input logic [15:0] m, input logic d);
    return d || (m <= (base_f >> 1));
  endfunction
  task finish_test();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait on one status bit; a hang ends the run
  task wait_bit(input int idx, input logic v);
    n = 0;
    while (status[idx] !== v) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 2000) begin
        err_count++;
        finish_test();
      end
    end
  endtask
  task power_up(input logic g, input logic r);
    @(negedge clock);
    srst <= 1;
    guard <= g;
    run_req <= r;
    repeat (3) @(negedge clock);
    srst <= 0;
  endtask
  task pulse_reset();
    @(negedge clock) reset_req <= 1;
    @(negedge clock) reset_req <= 0;
  endtask
  initial begin
    void'($urandom(34324));
    // guard off: carried-over run starts at once
    power_up(0, 1);
    wait_bit(4, 1);
    `CHK("guard_trip", 1'b0, status.guard_trip)
    // guard on: carried-over run trips, output held off
    power_up(1, 1);
    repeat (8) @(posedge clock);
    #1;
    `CHK("status", 5'b01100, status[4:0])
    `CHK("guard_error", 3'h1, guard_error)
    @(negedge clock) run_req <= 0;
    wait_bit(3, 0);
    `CHK("guard_error", 3'h0, guard_error)
    @(negedge clock) run_req <= 1;
    wait_bit(4, 1);
    `CHK("alarm", 1'b0, status.alarm)
    // undervoltage cleared by reset pulse re-runs the check
    @(negedge clock) uv <= 1;
    @(negedge clock) uv <= 0;
    pulse_reset();
    wait_bit(3, 1);
    `CHK("drive_on", 1'b0, status.drive_on)
    // reset terminal cancels trip while run stays on
    pulse_reset();
    wait_bit(4, 1);
    `CHK("alarm", 1'b0, status.alarm)
    power_up(1, 1);
    wait_bit(3, 1);
    @(negedge clock) key_rst <= 1;
    wait_bit(3, 0);
    `CHK("guard_error", 3'h0, guard_error)
    @(negedge clock) key_rst <= 0;
    // run raised only after the guard window: no trip
    power_up(1, 0);
    repeat (6) @(negedge clock);
    run_req <= 1;
    wait_bit(4, 1);
    `CHK("guard_error", 3'h0, guard_error)
    // switchover on random terminals, half base speed first
    power_up(0, 1);
    wait_bit(4, 1);
    for (int j = 0; j < 6; j++) begin
      @(negedge clock);
      k = $urandom_range(0, 6);
      tf = '{default: 5'h00};
      tf[k] = `SWITCHOVER_CODE;
      wait_t = 16'($urandom_range(1, 100) + 20 * j); // later passes lengthen the wait
      motor_f = (j == 0) ? (base_f >> 1) : 16'($urandom);
      fd = (j > 1) && ($urandom_range(0, 3) == 0);
      terms[k] <= 1;
      wait_bit(4, 0);
      @(negedge clock) terms[k] <= 0;
      wait_bit(1, 1);
      `CHK("waited", 1'b1, n >= int'(wait_t) && n <= int'(wait_t) + 8)
      `CHK("zero_start", zero_exp(motor_f, fd), status.zero_start)
      `CHK("start_freq", zero_exp(motor_f, fd) ? 16'h0000 : motor_f, start_freq)
      wait_bit(4, 1);
    end
    finish_test();
  end
endmodule // test_start_guard
